//--- pmd_pkg.sv
`default_nettype none
package pmd_pkg;

	// Link geometry and symbol store layout
	localparam int NUM_LANES   = 8;
	localparam int STORE_DEPTH = 8;
	localparam int OUT_DEPTH   = 16;
	localparam int ENTRY_W     = 10;
	localparam int ENTRY_K     = 8;
	localparam int ENTRY_DISP  = 9;

	// Special and training symbols
	localparam logic [7:0] SYM_COM   = 8'hBC;
	localparam logic [7:0] SYM_SKP   = 8'h1C;
	localparam logic [7:0] SYM_FTS   = 8'h3C;
	localparam logic [7:0] SYM_PAD   = 8'hF7;
	localparam logic [7:0] SYM_IDL   = 8'h7C;
	localparam logic [7:0] SYM_D00   = 8'h00;
	localparam logic [7:0] TS1_ID    = 8'h4A;
	localparam logic [7:0] TS2_ID    = 8'h45;
	localparam logic [7:0] LINK_NUM  = 8'h00;
	localparam logic [7:0] NFTS_VAL  = 8'h80;
	localparam logic [7:0] RATE_2G5  = 8'h02;
	localparam logic [7:0] RATE_5G0  = 8'h04;
	localparam logic [7:0] RATE_8G0  = 8'h08;
	localparam logic [7:0] RATE_CHG  = 8'h80;

	// Symbol positions inside ordered sets
	localparam logic [3:0] TS_IDX_LINK = 4'h1;
	localparam logic [3:0] TS_IDX_LANE = 4'h2;
	localparam logic [3:0] TS_IDX_NFTS = 4'h3;
	localparam logic [3:0] TS_IDX_RATE = 4'h4;
	localparam logic [3:0] TS_IDX_CTRL = 4'h5;
	localparam logic [3:0] TS_IDX_ID   = 4'h6;
	localparam logic [3:0] TS_LAST     = 4'hF;
	localparam logic [3:0] SKP_LAST    = 4'h3;

	// Rates as driven on the transceiver rate select; receiver-detected receive status
	localparam logic [1:0] RATE_SEL_G1 = 2'h0;
	localparam logic [1:0] RATE_SEL_G2 = 2'h1;
	localparam logic [1:0] RATE_SEL_G3 = 2'h2;
	localparam logic [2:0] RXST_DETECTED = 3'h3;

	// Counts and times
	localparam logic [3:0]  TS_NEEDED          = 4'h8;
	localparam logic [2:0]  DESKEW_TIMEOUT_CYC = 3'h7;
	localparam logic [10:0] SKP_INTERVAL_CYC   = 11'h49C;
	localparam int          CLK_PERIOD_NS      = 10;
	localparam int          DET_QUIET_MS       = 12;
	localparam int          TRAIN_TIMEOUT_MS   = 24;
	localparam int DET_QUIET_CYC = DET_QUIET_MS * 1000000 / CLK_PERIOD_NS;
	localparam int TRAIN_TO_CYC  = TRAIN_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;

	// Scrambler polynomial x16+x5+x4+x3+1
	localparam logic [15:0] SCR_SEED = 16'hFFFF;
	localparam logic [15:0] SCR_TAPS = 16'h0039;

	typedef enum logic [2:0] {ST_DET_QUIET, ST_DET_ACT, ST_POLL, ST_CFG,
		ST_L0, ST_RECOV, ST_SPEED} pmd_ltssm_t;
	typedef enum logic [1:0] {OS_IDLE, OS_TS1, OS_TS2, OS_SKP} pmd_os_t;
	typedef enum logic [1:0] {FLD_NONE, FLD_LINK, FLD_LANE} pmd_fld_t;

	// Returns {next lfsr, scrambled byte}
	function automatic logic [23:0] pmd_scr(input logic [15:0] s,
		input logic [7:0] d);
		logic [15:0] l;
		logic [7:0]  o;
		l = s;
		o = d;
		for (int b = 0; b < 8; b++) begin
			o[b] = d[b] ^ l[15];
			l = {l[14:0], 1'b0} ^ (l[15] ? SCR_TAPS : 16'h0000);
		end
		return {l, o};
	endfunction

endpackage
`default_nettype wire

//--- pmd_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module pmd_fifo
	import pmd_pkg::*;
#(
	parameter int WIDTH = 72,
	parameter int DEPTH = OUT_DEPTH
)(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             flush,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wp_r, wp_nxt, rp_r, rp_nxt;
	logic             wr, rd;

	always_comb begin
		in_ready  = !((wp_r[AW] != rp_r[AW]) &&
			(wp_r[AW-1:0] == rp_r[AW-1:0]));
		out_valid = wp_r != rp_r;
		wr        = in_valid && in_ready;
		rd        = out_valid && out_ready;
		wp_nxt    = wp_r + (AW+1)'(wr);
		rp_nxt    = rp_r + (AW+1)'(rd);
		if (flush) begin
			wp_nxt = '0;
			rp_nxt = '0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (wr)
			mem[wp_r[AW-1:0]] <= in_data;
	end

	assign out_data = mem[rp_r[AW-1:0]];

endmodule // pmd_fifo
`default_nettype wire

//--- pmd_lane_store.sv
`timescale 1ns/1ps
`default_nettype none
module pmd_lane_store
	import pmd_pkg::*;
#(
	parameter int DEPTH = STORE_DEPTH
)(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// Control from the deskew sequencer
	input  wire logic       clr,
	input  wire logic       en,
	input  wire logic       rd,
	// Received symbol
	input  wire logic       in_valid,
	input  wire logic [7:0] in_data,
	input  wire logic       in_k,
	input  wire logic       in_disp,
	// Status and stored symbol
	output logic            has_data,
	output logic            com_seen,
	output logic            overflow,
	output logic [7:0]      out_data,
	output logic            out_k,
	output logic            out_disp
);
	localparam int AW = $clog2(DEPTH);

	logic [ENTRY_W-1:0] mem [DEPTH];
	logic [ENTRY_W-1:0] ent;
	logic [AW:0]        wp_r, wp_nxt, rp_r, rp_nxt;
	logic               seen_r, seen_nxt;
	logic               drop, wr, full, com;

	always_comb begin
		com  = en && in_valid && in_k && (in_data == SYM_COM);
		drop = in_k && (in_data == SYM_FTS || in_data == SYM_COM ||
			in_data == SYM_SKP);
		ent  = {in_disp, in_k, in_data};
		if (in_k && (in_data == SYM_PAD || in_data == SYM_IDL))
			ent = {in_disp, 1'b0, SYM_D00};
		full     = (wp_r[AW] != rp_r[AW]) &&
			(wp_r[AW-1:0] == rp_r[AW-1:0]);
		wr       = en && seen_r && in_valid && !drop;
		overflow = wr && full && !rd;
		seen_nxt = (clr ? 1'b0 : seen_r) | com;
		wp_nxt   = wp_r + (AW+1)'(wr && !overflow);
		rp_nxt   = rp_r + (AW+1)'(rd);
		if (clr) begin
			wp_nxt = '0;
			rp_nxt = '0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wp_r   <= '0;
			rp_r   <= '0;
			seen_r <= 1'b0;
		end else begin
			wp_r   <= wp_nxt;
			rp_r   <= rp_nxt;
			seen_r <= seen_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (wr && !overflow)
			mem[wp_r[AW-1:0]] <= ent;
	end

	assign has_data = wp_r != rp_r;
	assign com_seen = seen_r;
	assign out_data = mem[rp_r[AW-1:0]][7:0];
	assign out_k    = mem[rp_r[AW-1:0]][ENTRY_K];
	assign out_disp = mem[rp_r[AW-1:0]][ENTRY_DISP];

endmodule // pmd_lane_store
`default_nettype wire

//--- pmd_link_media_access_sublayer.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - Deskew keeps one eight-word store per lane.
// - Each stored entry holds eight data bits, disparity and control flag.
// - Stores drop FTS, COM, SKP; PAD and IDL become D0.0.
// - Stores are read only when every lane store holds data.
// - After enable each lane starts writing only after its first COM.
// - Missing COM on any lane after seven cycles resets all stores.
// - Aligned lane symbols form one 64-bit word for the link layer.
// - Receive lanes count TS1 and TS2 sets for the training machine.
// - Transmit lanes choose link-layer traffic or generator output.
// - Transmit lanes insert lane number; disabled lanes send PAD.
// - Training machine tracks lanes and drives global and per-lane controls.
// - Training machine takes lane reports, enables deskew, reports status.
// - Same ordered set on all lanes not disabled; unassigned link/lane fields are PAD.
// - Receiver detect drives the request and waits for the result.
// - SKP sets are scheduled periodically but never inside a packet.
// - Data is scrambled at the lower rates and sent unscrambled at the top rate.
// - Scrambling, descrambling and deskew are done here, above the PHY.
// - Reversed lane order is detected and the lane map reversed.
// - Link speed is negotiated and changed autonomously.
module pmd_link_media_access_sublayer
	import pmd_pkg::*;
#(
	parameter int DET_QUIET = DET_QUIET_CYC,
	parameter int TRAIN_TO  = TRAIN_TO_CYC
)(
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       nrst,
	// Transceiver transmit side
	output logic [NUM_LANES-1:0][7:0]       pipe_txdata,
	output logic [NUM_LANES-1:0]            pipe_txdatak,
	output logic                            pipe_txdetectrx,
	output logic                            pipe_txelecidle,
	output logic [1:0]                      pipe_rate,
	// Transceiver receive side
	input  wire logic [NUM_LANES-1:0][7:0]  pipe_rxdata,
	input  wire logic [NUM_LANES-1:0]       pipe_rxdatak,
	input  wire logic [NUM_LANES-1:0]       pipe_rxdisp,
	input  wire logic [NUM_LANES-1:0]       pipe_rxvalid,
	input  wire logic                       pipe_phystatus,
	input  wire logic [2:0]                 pipe_rxstatus,
	// Link layer transmit
	input  wire logic [NUM_LANES-1:0][7:0]  dll_tx_data,
	input  wire logic [NUM_LANES-1:0]       dll_tx_k,
	input  wire logic                       dll_tx_valid,
	output logic                            dll_tx_ready,
	// Link layer receive
	output logic [63:0]                     dll_rx_data,
	output logic [7:0]                      dll_rx_k,
	output logic                            dll_rx_valid,
	input  wire logic                       dll_rx_ready,
	// Control and status
	input  wire logic [1:0]                 max_rate,
	output logic                            link_up,
	output pmd_ltssm_t                      ltssm_state,
	output logic                            lanes_reversed,
	output logic [NUM_LANES-1:0]            lanes_disabled
);
	localparam int L = NUM_LANES;

	////////////////////////////////////////////////////////////////////////
	// Link training state machine
	pmd_ltssm_t            st_r, st_nxt;
	pmd_os_t               os_want;
	logic [23:0]           tmr_r, tmr_nxt;
	logic [1:0]            rate_r, rate_nxt, partner, target;
	logic                  rev_r, rev_nxt;
	logic [L-1:0]          dis_r, dis_nxt;
	logic [L-1:0]          ts1_ok, ts2_ok;
	logic [L-1:0][7:0]     rlane, rrate;
	logic [3:0]            ts2_cnt0;
	logic                  det_req, det_done, det_ok, cnt_clr, deskew_en;
	logic                  assigned, tmo;

	always_comb begin
		partner = rrate[0][3] ? RATE_SEL_G3 :
			(rrate[0][2] ? RATE_SEL_G2 : RATE_SEL_G1);
		target  = (max_rate < partner) ? max_rate : partner;
		tmo     = tmr_r == 24'(TRAIN_TO);
		st_nxt  = st_r;
		tmr_nxt = tmr_r + 24'h000001;
		rate_nxt = rate_r;
		rev_nxt = rev_r;
		dis_nxt = dis_r;
		det_req = 1'b0;
		os_want = OS_TS1;
		case (st_r)
			ST_DET_QUIET: begin
				os_want  = OS_IDLE;
				rate_nxt = RATE_SEL_G1;
				rev_nxt  = 1'b0;
				dis_nxt  = '0;
				if (tmr_r == 24'(DET_QUIET))
					st_nxt = ST_DET_ACT;
			end
			ST_DET_ACT: begin
				os_want = OS_IDLE;
				det_req = 1'b1;
				if (det_done)
					st_nxt = det_ok ? ST_POLL : ST_DET_QUIET;
			end
			ST_POLL: begin
				if (&(ts1_ok | ts2_ok))
					st_nxt = ST_CFG;
				else if (tmo)
					st_nxt = ST_DET_QUIET;
			end
			ST_CFG: begin
				os_want = OS_TS2;
				if (ts2_cnt0 != 4'h0 && rlane[0] == 8'(L-1))
					rev_nxt = 1'b1;
				if (&(ts2_ok | dis_r))
					st_nxt = ST_L0;
				else if (tmo) begin
					dis_nxt = dis_r | ~ts2_ok;
					tmr_nxt = '0;
					if (&(dis_r | ~ts2_ok))
						st_nxt = ST_DET_QUIET;
				end
			end
			ST_L0: begin
				os_want = OS_IDLE;
				if (target != rate_r)
					st_nxt = ST_RECOV;
			end
			ST_RECOV: begin
				if (&(ts1_ok | dis_r))
					st_nxt = ST_SPEED;
				else if (tmo)
					st_nxt = ST_DET_QUIET;
			end
			ST_SPEED: begin
				os_want  = OS_IDLE;
				rate_nxt = target;
				if (pipe_phystatus)
					st_nxt = ST_L0;
				else if (tmo)
					st_nxt = ST_DET_QUIET;
			end
			default: st_nxt = ST_DET_QUIET;
		endcase
		if (st_nxt != st_r)
			tmr_nxt = '0;
		cnt_clr   = st_nxt != st_r;
		deskew_en = st_r == ST_L0;
		assigned  = st_r inside {ST_CFG, ST_L0, ST_RECOV, ST_SPEED};
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_r   <= ST_DET_QUIET;
			tmr_r  <= '0;
			rate_r <= RATE_SEL_G1;
			rev_r  <= 1'b0;
			dis_r  <= '0;
		end else begin
			st_r   <= st_nxt;
			tmr_r  <= tmr_nxt;
			rate_r <= rate_nxt;
			rev_r  <= rev_nxt;
			dis_r  <= dis_nxt;
		end
	end

	assign link_up         = deskew_en;
	assign ltssm_state     = st_r;
	assign lanes_reversed  = rev_r;
	assign lanes_disabled  = dis_r;
	assign pipe_rate       = rate_r;
	assign pipe_txelecidle = st_r inside {ST_DET_QUIET, ST_DET_ACT};

	////////////////////////////////////////////////////////////////////////
	// Ordered set and SKP generator, receiver detection
	pmd_os_t     gk_r, gk_nxt;
	pmd_fld_t    g_fld;
	logic [3:0]  gi_r, gi_nxt;
	logic [10:0] skp_r, skp_nxt;
	logic        pend_r, pend_nxt, busy_r, busy_nxt;
	logic [7:0]  g_sym, g_rate;
	logic        g_k, g_scr, g_last, use_dll;

	always_comb begin
		g_rate = RATE_2G5 | ((max_rate >= RATE_SEL_G2) ? RATE_5G0 : 8'h00) |
			((max_rate >= RATE_SEL_G3) ? RATE_8G0 : 8'h00) |
			((st_r == ST_RECOV) ? RATE_CHG : 8'h00);
		g_sym = SYM_D00;
		g_k   = 1'b0;
		g_fld = FLD_NONE;
		g_scr = 1'b0;
		case (gk_r)
			OS_TS1, OS_TS2: begin
				g_sym = (gk_r == OS_TS1) ? TS1_ID : TS2_ID;
				case (gi_r)
					4'h0: begin
						g_sym = SYM_COM;
						g_k   = 1'b1;
					end
					TS_IDX_LINK: begin
						g_sym = LINK_NUM;
						g_fld = FLD_LINK;
					end
					TS_IDX_LANE: g_fld = FLD_LANE;
					TS_IDX_NFTS: g_sym = NFTS_VAL;
					TS_IDX_RATE: g_sym = g_rate;
					TS_IDX_CTRL: g_sym = SYM_D00;
					default: ;
				endcase
			end
			OS_SKP: begin
				g_k   = 1'b1;
				g_sym = (gi_r == 4'h0) ? SYM_COM : SYM_SKP;
			end
			default: g_scr = 1'b1;
		endcase
		g_last = (gk_r == OS_SKP) ? (gi_r == SKP_LAST) :
			((gk_r == OS_IDLE) || (gi_r == TS_LAST));
		gk_nxt   = gk_r;
		gi_nxt   = gi_r + 4'h1;
		skp_nxt  = skp_r + 11'h001;
		pend_nxt = pend_r;
		if (g_last) begin
			gi_nxt = 4'h0;
			if (pend_r && !(st_r == ST_L0 && dll_tx_valid)) begin
				gk_nxt   = OS_SKP;
				pend_nxt = 1'b0;
			end else
				gk_nxt = os_want;
		end
		if (skp_r == SKP_INTERVAL_CYC - 11'h001) begin
			skp_nxt  = '0;
			pend_nxt = 1'b1;
		end
		det_done = busy_r && pipe_phystatus;
		det_ok   = det_done && (pipe_rxstatus == RXST_DETECTED);
		busy_nxt = det_done ? 1'b0 : (busy_r | det_req);
		dll_tx_ready = (st_r == ST_L0) && (gk_r == OS_IDLE);
		use_dll  = dll_tx_valid && dll_tx_ready;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gk_r   <= OS_IDLE;
			gi_r   <= '0;
			skp_r  <= '0;
			pend_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			gk_r   <= gk_nxt;
			gi_r   <= gi_nxt;
			skp_r  <= skp_nxt;
			pend_r <= pend_nxt;
			busy_r <= busy_nxt;
		end
	end

	assign pipe_txdetectrx = busy_r;

	////////////////////////////////////////////////////////////////////////
	// Per-lane transmit and receive logic
	logic [L-1:0][7:0] rx_d;

	for (genvar i = 0; i < L; i++) begin : g_lane
		logic [15:0] scr_r, scr_nxt, ds_r, ds_nxt;
		logic [7:0]  d_r, d_nxt, sym, ln_r, ln_nxt, rt_r, rt_nxt, dd;
		logic [3:0]  ri_r, ri_nxt, c1_r, c1_nxt, c2_r, c2_nxt;
		logic [23:0] so, dso;
		logic        k_r, k_nxt, sk, sen, rk;

		always_comb begin
			sym = g_sym;
			sk  = g_k;
			sen = g_scr;
			if (g_fld == FLD_LINK && !assigned) begin
				sym = SYM_PAD;
				sk  = 1'b1;
			end
			if (g_fld == FLD_LANE) begin
				sym = assigned ? (rev_r ? 8'(L-1-i) : 8'(i)) : SYM_PAD;
				sk  = !assigned;
			end
			if (use_dll) begin
				sym = dll_tx_data[i];
				sk  = dll_tx_k[i];
				sen = !dll_tx_k[i];
			end
			if (dis_r[i]) begin
				sym = SYM_PAD;
				sk  = 1'b1;
				sen = 1'b0;
			end
			so      = pmd_scr(scr_r, sym);
			scr_nxt = so[23:8];
			if (sk && sym == SYM_COM)
				scr_nxt = SCR_SEED;
			else if (sk && sym == SYM_SKP)
				scr_nxt = scr_r;
			d_nxt = (sen && rate_r != RATE_SEL_G3) ? so[7:0] : sym;
			k_nxt = sk;

			rk     = pipe_rxdatak[i];
			dso    = pmd_scr(ds_r, pipe_rxdata[i]);
			dd     = pipe_rxdata[i];
			ds_nxt = ds_r;
			ri_nxt = ri_r;
			ln_nxt = ln_r;
			rt_nxt = rt_r;
			c1_nxt = cnt_clr ? 4'h0 : c1_r;
			c2_nxt = cnt_clr ? 4'h0 : c2_r;
			if (pipe_rxvalid[i]) begin
				if (rk && pipe_rxdata[i] == SYM_COM) begin
					ri_nxt = 4'h1;
					ds_nxt = SCR_SEED;
				end else if (rk && pipe_rxdata[i] == SYM_SKP)
					ri_nxt = 4'h0;
				else begin
					ri_nxt = (ri_r == TS_LAST || ri_r == 4'h0) ? 4'h0 :
						ri_r + 4'h1;
					ds_nxt = dso[23:8];
					if (ri_r == 4'h0 && !rk && rate_r != RATE_SEL_G3)
						dd = dso[7:0];
				end
				if (ri_r == TS_IDX_LANE)
					ln_nxt = pipe_rxdata[i];
				if (ri_r == TS_IDX_RATE)
					rt_nxt = pipe_rxdata[i];
				if (ri_r == TS_IDX_ID && !rk) begin
					if (pipe_rxdata[i] == TS1_ID && c1_nxt != 4'hF)
						c1_nxt = c1_nxt + 4'h1;
					if (pipe_rxdata[i] == TS2_ID && c2_nxt != 4'hF)
						c2_nxt = c2_nxt + 4'h1;
				end
			end
		end

		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				scr_r <= SCR_SEED;
				d_r   <= SYM_D00;
				k_r   <= 1'b0;
				ds_r  <= SCR_SEED;
				ri_r  <= '0;
				ln_r  <= '0;
				rt_r  <= '0;
				c1_r  <= '0;
				c2_r  <= '0;
			end else begin
				scr_r <= scr_nxt;
				d_r   <= d_nxt;
				k_r   <= k_nxt;
				ds_r  <= ds_nxt;
				ri_r  <= ri_nxt;
				ln_r  <= ln_nxt;
				rt_r  <= rt_nxt;
				c1_r  <= c1_nxt;
				c2_r  <= c2_nxt;
			end
		end

		assign pipe_txdata[i]  = d_r;
		assign pipe_txdatak[i] = k_r;
		assign rx_d[i]   = dd;
		assign rlane[i]  = ln_r;
		assign rrate[i]  = rt_r;
		assign ts1_ok[i] = c1_r >= TS_NEEDED;
		assign ts2_ok[i] = c2_r >= TS_NEEDED;
		if (i == 0) begin : g_l0
			assign ts2_cnt0 = c2_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Multilane deskew and receive alignment
	logic [L-1:0]      has, cs, ovf, wk;
	logic [L-1:0][7:0] wd;
	logic [2:0]        dt_r, dt_nxt;
	logic              dsk_clr, st_rd, of_ready;
	logic [71:0]       of_out;

	always_comb begin
		dsk_clr = !deskew_en || (|ovf) ||
			(dt_r == DESKEW_TIMEOUT_CYC - 3'h1 && !(&cs));
		dt_nxt  = dt_r;
		if (dsk_clr)
			dt_nxt = '0;
		else if (!(&cs))
			dt_nxt = dt_r + 3'h1;
		st_rd = (&has) && of_ready && !dsk_clr;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			dt_r <= '0;
		else
			dt_r <= dt_nxt;
	end

	for (genvar j = 0; j < L; j++) begin : g_dsk
		pmd_lane_store #(
			.DEPTH    (STORE_DEPTH)
		) u_store (
			.clk      (clk),
			.nrst     (nrst),
			.clr      (dsk_clr),
			.en       (deskew_en),
			.rd       (st_rd),
			.in_valid (pipe_rxvalid[rev_r ? L-1-j : j]),
			.in_data  (rx_d[rev_r ? L-1-j : j]),
			.in_k     (pipe_rxdatak[rev_r ? L-1-j : j]),
			.in_disp  (pipe_rxdisp[rev_r ? L-1-j : j]),
			.has_data (has[j]),
			.com_seen (cs[j]),
			.overflow (ovf[j]),
			.out_data (wd[j]),
			.out_k    (wk[j]),
			.out_disp ()
		);
	end

	pmd_fifo #(
		.WIDTH     (72),
		.DEPTH     (OUT_DEPTH)
	) u_out (
		.clk       (clk),
		.nrst      (nrst),
		.flush     (dsk_clr),
		.in_valid  (st_rd),
		.in_ready  (of_ready),
		.in_data   ({wk, wd}),
		.out_valid (dll_rx_valid),
		.out_ready (dll_rx_ready),
		.out_data  (of_out)
	);

	assign dll_rx_data = of_out[63:0];
	assign dll_rx_k    = of_out[71:64];

endmodule // pmd_link_media_access_sublayer
`default_nettype wire

//--- pmd_lmas_props.sv
`timescale 1ns/1ps
`default_nettype none
module pmd_lmas_props
	import pmd_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Transceiver side
	input wire logic [7:0][7:0] pipe_txdata,
	input wire logic [7:0] pipe_txdatak,
	input wire logic pipe_txdetectrx,
	input wire logic pipe_phystatus,
	input wire logic [2:0] pipe_rxstatus,
	// Link layer side
	input wire logic [7:0][7:0] dll_tx_data,
	input wire logic [7:0] dll_tx_k,
	input wire logic dll_tx_valid,
	input wire logic dll_tx_ready,
	input wire logic [63:0] dll_rx_data,
	input wire logic dll_rx_valid,
	input wire logic dll_rx_ready,
	// Status
	input wire logic link_up,
	input wire pmd_ltssm_t ltssm_state
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	////////////////////////////////////////
	property p_det_rise;
		$rose(ltssm_state == ST_DET_ACT) |-> ##[0:2] pipe_txdetectrx;
	endproperty
	a_det_rise: assert property (p_det_rise) else $error("detect late");
	property p_det_hold;
		pipe_txdetectrx && !pipe_phystatus |=> pipe_txdetectrx;
	endproperty
	a_det_hold: assert property (p_det_hold) else $error("detect lost");
	property p_det_ok;
		pipe_txdetectrx && pipe_phystatus && pipe_rxstatus == RXST_DETECTED
		|-> ##[1:2] ltssm_state == ST_POLL;
	endproperty
	a_det_ok: assert property (p_det_ok) else $error("no polling");
	property p_ready_l0;
		dll_tx_ready |-> link_up && ltssm_state == ST_L0;
	endproperty
	a_ready_l0: assert property (p_ready_l0) else $error("ready early");
	property p_tx_k;
		dll_tx_valid && dll_tx_ready && dll_tx_k[0]
		|=> pipe_txdatak[0] && pipe_txdata[0] == $past(dll_tx_data[0]);
	endproperty
	a_tx_k: assert property (p_tx_k) else $error("tx byte lost");
	property p_same_os;
		ltssm_state == ST_POLL |-> pipe_txdata == {8{pipe_txdata[0]}};
	endproperty
	a_same_os: assert property (p_same_os) else $error("lanes differ");
	property p_rx_hold;
		dll_rx_valid && !dll_rx_ready && link_up
		|=> !dll_rx_valid || $stable(dll_rx_data);
	endproperty
	a_rx_hold: assert property (p_rx_hold) else $error("rx word lost");
	property p_skp_gap;
		dll_tx_valid && dll_tx_ready
		|=> !(pipe_txdatak[0] && pipe_txdata[0] == SYM_COM);
	endproperty
	a_skp_gap: assert property (p_skp_gap) else $error("set in packet");
endmodule // pmd_lmas_props
bind pmd_link_media_access_sublayer pmd_lmas_props pmd_lmas_props_i (.*);
`default_nettype wire

//--- pmd_pcs_model.sv
`timescale 1ns/1ps
`default_nettype none
module pmd_pcs_model
	import pmd_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Block transmit side and bench control
	input wire logic [7:0][7:0] pipe_txdata,
	input wire logic [7:0] pipe_txdatak,
	input wire logic pipe_txdetectrx,
	input wire logic pipe_txelecidle,
	input wire logic present,
	input wire logic inject,
	input wire logic [7:0][7:0] inj_data,
	input wire logic [7:0] inj_k,
	input wire logic [7:0] inj_valid,
	// Block receive side
	output logic [7:0][7:0] pipe_rxdata,
	output logic [7:0] pipe_rxdatak,
	output logic [7:0] pipe_rxdisp,
	output logic [7:0] pipe_rxvalid,
	output logic pipe_phystatus,
	output logic [2:0] pipe_rxstatus
);
	logic [2:0] cnt;
	logic hit;
	// Present receivers answer fast, absent ones slowly
	assign hit = pipe_txdetectrx && !pipe_phystatus
		&& cnt == (present ? 3'h2 : 3'h6);
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			{pipe_rxdata, pipe_rxdatak, pipe_rxdisp, pipe_rxvalid} <= '0;
			{pipe_phystatus, pipe_rxstatus, cnt} <= '0;
		end else begin
			// Link loops back unless the bench injects symbols
			pipe_rxdata <= inject ? inj_data : pipe_txdata;
			pipe_rxdatak <= inject ? inj_k : pipe_txdatak;
			pipe_rxvalid <= inject ? inj_valid : {8{!pipe_txelecidle}};
			pipe_rxdisp <= ~pipe_rxdisp;
			pipe_phystatus <= hit;
			pipe_rxstatus <= hit ? (present ? RXST_DETECTED : 3'h0)
				: ~pipe_rxstatus;
			cnt <= pipe_txdetectrx && !hit && !pipe_phystatus ? cnt + 3'h1 : 3'h0;
		end
	end
endmodule // pmd_pcs_model
`default_nettype wire

//--- test_pmd_link_media_access_sublayer.sv
`timescale 1ns/1ps
`default_nettype none
module test_pmd_link_media_access_sublayer;
	import pmd_pkg::*;
	logic clk, nrst, present, inject, dll_tx_valid, dll_rx_ready;
	logic pipe_txdetectrx, pipe_txelecidle, pipe_phystatus, dll_tx_ready;
	logic dll_rx_valid, link_up, lanes_reversed;
	logic [7:0][7:0] inj_data, dll_tx_data, pipe_txdata, pipe_rxdata;
	logic [7:0] inj_k, inj_valid, dll_tx_k, pipe_txdatak, pipe_rxdatak;
	logic [7:0] pipe_rxdisp, pipe_rxvalid, lanes_disabled, dll_rx_k;
	logic [2:0] pipe_rxstatus;
	logic [1:0] pipe_rate, max_rate;
	logic [63:0] dll_rx_data;
	pmd_ltssm_t ltssm_state;
	int error_cnt = 0;
	int n_compared = 0;
	pmd_link_media_access_sublayer #(.DET_QUIET(20), .TRAIN_TO(400))
		pmd_link_media_access_sublayer_i (.*);
	pmd_pcs_model pmd_pcs_model_i (.*);
	////////////////////////////////////////
	task automatic check(string what, logic [63:0] exp, logic [63:0] got);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic cyc(int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wait_st(pmd_ltssm_t s, int lim);
		for (int i = 0; i < lim && ltssm_state !== s; i++)
			@(negedge clk);
		check("state", s, ltssm_state);
	endtask
	// Lane field of the next training set on lane 3
	task automatic lane_field(logic [7:0] exp);
		for (int i = 0; i < 40 && !(pipe_txdatak[3]
			&& pipe_txdata[3] == SYM_COM); i++)
			@(negedge clk);
		cyc(2);
		check("lane field", exp, pipe_txdata[3]);
	endtask
	////////////////////////////////////////
	task automatic t_reset();
		@(negedge clk);
		check("elecidle", 1, pipe_txelecidle);
		check("tx ready", 0, dll_tx_ready);
		check("rx valid", 0, dll_rx_valid);
		@(posedge clk);
		nrst <= 1;
		$display("reset test done");
	endtask
	task automatic t_absent();
		for (int i = 0; i < 60 && pipe_phystatus !== 1; i++)
			@(negedge clk);
		check("phystatus", 1, pipe_phystatus);
		cyc(2);
		check("state", ST_DET_QUIET, ltssm_state);
		check("detect", 0, pipe_txdetectrx);
		@(posedge clk);
		present <= 1;
		$display("absent receiver test done");
	endtask
	task automatic t_train();
		wait_st(ST_POLL, 80);
		lane_field(SYM_PAD);
		wait_st(ST_CFG, 400);
		cyc(20);
		lane_field(8'h03);
		wait_st(ST_L0, 600);
		check("link up", 1, link_up);
		check("reversed", 0, lanes_reversed);
		check("disabled", 0, lanes_disabled);
		check("rate", RATE_SEL_G1, pipe_rate);
		$display("training test done");
	endtask
	task automatic t_tx();
		for (int i = 0; i < 1300 && dll_tx_ready !== 1; i++)
			@(negedge clk);
		@(posedge clk);
		dll_tx_valid <= 1;
		dll_tx_k <= 8'hFF;
		dll_tx_data <= {8{8'hFB}};
		@(negedge clk);
		for (int i = 0; i < 10 && dll_tx_ready !== 1; i++)
			@(negedge clk);
		@(posedge clk);
		dll_tx_valid <= 0;
		@(negedge clk);
		check("tx data", {8{8'hFB}}, pipe_txdata);
		check("tx k", 8'hFF, pipe_txdatak);
		$display("transmit test done");
	endtask
	// Stall until overflow flushes, then high lanes see their comma late
	task automatic t_rx();
		int n = 0;
		logic [63:0] w = '1;
		logic [7:0] k = '1;
		cyc(1300);
		check("loop valid", 1, dll_rx_valid);
		check("loop data", 0, dll_rx_data);
		@(posedge clk);
		dll_rx_ready <= 0;
		@(negedge clk);
		for (int i = 0; i < 60 && dll_rx_valid !== 0; i++)
			@(negedge clk);
		check("flush", 0, dll_rx_valid);
		@(posedge clk);
		dll_rx_ready <= 1;
		inject <= 1;
		inj_k <= 8'hFF;
		inj_valid <= 8'hFF;
		inj_data <= {{4{SYM_IDL}}, {4{SYM_COM}}};
		@(posedge clk);
		inj_data <= {{4{SYM_COM}}, {4{SYM_PAD}}};
		@(posedge clk);
		inj_data <= {8{SYM_IDL}};
		@(posedge clk);
		inj_data <= {{4{SYM_SKP}}, {4{SYM_FTS}}};
		@(posedge clk);
		inj_valid <= 8'h00;
		repeat (20) begin
			@(negedge clk);
			if (dll_rx_valid === 1) begin
				n++;
				w = dll_rx_data;
				k = dll_rx_k;
			end
		end
		check("words", 1, n);
		check("rx data", 0, w);
		check("rx k", 0, k);
		$display("deskew test done");
	endtask
	////////////////////////////////////////
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (8000) @(posedge clk);
		error_cnt++;
		$display("unexpected run time: expected end seen hang");
		give_verdict();
	end
	initial begin
		{nrst, present, inject, dll_tx_valid, max_rate} = '0;
		{inj_data, inj_k, inj_valid, dll_tx_data, dll_tx_k} = '0;
		dll_rx_ready = 1;
		repeat (3) @(posedge clk);
		t_reset();
		t_absent();
		t_train();
		t_tx();
		t_rx();
		give_verdict();
	end
endmodule // test_pmd_link_media_access_sublayer
`default_nettype wire
